// ### logic/i2ct_pkg.sv
// Constants, types and defaults shared by the I2C target register front end
`default_nettype none
package i2ct_pkg;
  // Fixed parts of the 7-bit target address
  localparam logic [2:0] I2CT_ADDR_HI = 3'h4;
  localparam logic [1:0] I2CT_ADDR_LO = 2'h3;
  localparam int I2CT_ADDR_HI_POS = 4;
  localparam int I2CT_ADDR_SEL_POS = 2;

  // Register offsets and register store sizes
  localparam logic [7:0] I2CT_OFS_RSVD0 = 8'h00;
  localparam logic [7:0] I2CT_OFS_FIRST_RW = 8'h01;
  localparam logic [7:0] I2CT_OFS_LINK_CTRL1 = 8'h02;
  localparam logic [7:0] I2CT_OFS_LINK_CTRL2 = 8'h03;
  localparam logic [7:0] I2CT_OFS_LAST_RW = 8'h0A;
  localparam logic [7:0] I2CT_OFS_SIGNATURE = 8'h0D;
  localparam logic [7:0] I2CT_OFS_VDX_CTRL = 8'h0E;
  localparam logic [7:0] I2CT_OFS_DEV_STATUS = 8'h0F;
  localparam logic [7:0] I2CT_OFS_LINK_STATUS = 8'h10;
  localparam logic [7:0] I2CT_OFS_RAZ_LO = 8'h11;
  localparam logic [7:0] I2CT_OFS_RAZ_HI = 8'h12;
  localparam int I2CT_NUM_STORED = 16;
  localparam int I2CT_CFG_BYTES = 14;

  // Values after power-on reset, and the value read from undefined offsets
  localparam logic [7:0] I2CT_RST_ZERO = 8'h00;
  localparam logic [7:0] I2CT_RST_EUSB_RX = 8'h20;
  localparam logic [7:0] I2CT_RST_EUSB_TX = 8'h10;
  localparam logic [7:0] I2CT_RST_USB_RX = 8'h40;
  localparam logic [7:0] I2CT_RST_USB_TX1 = 8'h22;
  localparam logic [7:0] I2CT_RST_USB_TX2 = 8'h63;
  localparam logic [7:0] I2CT_RST_USB_TERM = 8'h02;
  localparam logic [7:0] I2CT_UNDEF_READ = 8'hFF;

  // Cycles after reset release before the strap level is taken, and bits per byte
  localparam logic [3:0] I2CT_STRAP_SETTLE_CYCLES = 4'hA;
  localparam logic [3:0] I2CT_BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    I2CT_STRAP_VDD,
    I2CT_STRAP_PU56K,
    I2CT_STRAP_PU200K,
    I2CT_STRAP_GND
  } i2ct_strap_t;

  typedef enum logic [3:0] {
    I2CT_IDLE,
    I2CT_ADDR,
    I2CT_ADDR_ACK,
    I2CT_OFFS,
    I2CT_OFFS_ACK,
    I2CT_WDATA,
    I2CT_WDATA_ACK,
    I2CT_RDATA,
    I2CT_RACK
  } i2ct_state_t;

  function automatic logic [7:0] reset_value(input logic [3:0] idx);
    case (idx)
      4'h4: reset_value = I2CT_RST_EUSB_RX;
      4'h5: reset_value = I2CT_RST_EUSB_TX;
      4'h6: reset_value = I2CT_RST_USB_RX;
      4'h7: reset_value = I2CT_RST_USB_TX1;
      4'h8: reset_value = I2CT_RST_USB_TX2;
      4'h9: reset_value = I2CT_RST_USB_TERM;
      default: reset_value = I2CT_RST_ZERO;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### logic/i2ct_regfile.sv
// Configuration register store with registered read port
`default_nettype none
`timescale 1ns/1ps
module i2ct_regfile (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hold_clr,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_ff,
  input wire logic [7:0] dev_status,
  input wire logic [7:0] link_status,
  output logic [8*i2ct_pkg::I2CT_CFG_BYTES-1:0] cfg_regs
);
  logic [7:0] regs_ff [0:i2ct_pkg::I2CT_NUM_STORED-1];

  function automatic logic writable(input logic [7:0] a);
    writable = (a >= i2ct_pkg::I2CT_OFS_FIRST_RW &&
                a <= i2ct_pkg::I2CT_OFS_LAST_RW) ||
               a == i2ct_pkg::I2CT_OFS_SIGNATURE ||
               a == i2ct_pkg::I2CT_OFS_VDX_CTRL;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < i2ct_pkg::I2CT_NUM_STORED; i++) begin
        regs_ff[i] <= i2ct_pkg::reset_value(4'(i));
      end
    end else if (hold_clr) begin
      // Link control and signature are lost while the part is held
      regs_ff[i2ct_pkg::I2CT_OFS_LINK_CTRL1[3:0]] <= i2ct_pkg::I2CT_RST_ZERO;
      regs_ff[i2ct_pkg::I2CT_OFS_LINK_CTRL2[3:0]] <= i2ct_pkg::I2CT_RST_ZERO;
      regs_ff[i2ct_pkg::I2CT_OFS_SIGNATURE[3:0]] <= i2ct_pkg::I2CT_RST_ZERO;
    end else if (wr_en && writable(wr_addr)) begin
      regs_ff[wr_addr[3:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data_ff <= i2ct_pkg::I2CT_RST_ZERO;
    end else if (writable(rd_addr)) begin
      rd_data_ff <= regs_ff[rd_addr[3:0]];
    end else if (rd_addr == i2ct_pkg::I2CT_OFS_DEV_STATUS) begin
      rd_data_ff <= dev_status;
    end else if (rd_addr == i2ct_pkg::I2CT_OFS_LINK_STATUS) begin
      rd_data_ff <= link_status;
    end else if (rd_addr == i2ct_pkg::I2CT_OFS_RSVD0 ||
                 rd_addr == i2ct_pkg::I2CT_OFS_RAZ_LO ||
                 rd_addr == i2ct_pkg::I2CT_OFS_RAZ_HI) begin
      rd_data_ff <= i2ct_pkg::I2CT_RST_ZERO;
    end else begin
      rd_data_ff <= i2ct_pkg::I2CT_UNDEF_READ;
    end
  end

  for (genvar g = 0; g < i2ct_pkg::I2CT_CFG_BYTES; g++) begin : g_cfg
    assign cfg_regs[8*g +: 8] = regs_ff[g+1];
  end
endmodule
`default_nettype wire

// ### logic/i2ct_target.sv
// I2C target front end: address decode, offset pointer, byte transfers
`default_nettype none
`timescale 1ns/1ps
module i2ct_target (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o_ff,
  output logic sda_oe_n_ff,
  input wire logic [1:0] strap_level,
  input wire logic hold_rst_n,
  input wire logic [7:0] dev_status,
  input wire logic [7:0] link_status,
  output logic [8*i2ct_pkg::I2CT_CFG_BYTES-1:0] cfg_regs,
  output logic [1:0] addr_sel_ff,
  output logic usb_hiz_ff,
  output logic usb_pd_en_ff
);
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic hold_s1_ff, hold_s2_ff;
  logic [1:0] strap_s1_ff, strap_s2_ff;
  logic [3:0] settle_ff;
  logic strap_done_ff;
  i2ct_pkg::i2ct_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic rd_dir_ff;
  logic master_ack_ff;
  logic wr_en_ff;
  logic [7:0] wr_data_ff;
  logic [7:0] rd_data;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic byte_done, addr_match, ack_slot;

  function automatic logic [1:0] strap_to_bits(input logic [1:0] lvl);
    case (i2ct_pkg::i2ct_strap_t'(lvl))
      i2ct_pkg::I2CT_STRAP_VDD: strap_to_bits = 2'h0;
      i2ct_pkg::I2CT_STRAP_PU56K: strap_to_bits = 2'h1;
      i2ct_pkg::I2CT_STRAP_PU200K: strap_to_bits = 2'h2;
      default: strap_to_bits = 2'h3;
    endcase
  endfunction

  // Pins from outside the clock domain; SCL is only ever observed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_s1_ff <= 1'h1;
      scl_s2_ff <= 1'h1;
      scl_d_ff <= 1'h1;
      sda_s1_ff <= 1'h1;
      sda_s2_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_s1_ff <= 1'h1;
      hold_s2_ff <= 1'h1;
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
    end else begin
      hold_s1_ff <= hold_rst_n;
      hold_s2_ff <= hold_s1_ff;
      strap_s1_ff <= strap_level;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Strap is caught once, after the level has settled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      settle_ff <= 4'h0;
      strap_done_ff <= 1'h0;
      addr_sel_ff <= 2'h0;
    end else if (!strap_done_ff) begin
      settle_ff <= settle_ff + 4'h1;
      if (settle_ff == i2ct_pkg::I2CT_STRAP_SETTLE_CYCLES) begin
        strap_done_ff <= 1'h1;
        addr_sel_ff <= strap_to_bits(strap_s2_ff);
      end
    end
  end

  // Held low: USB pins released to another chip
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      usb_hiz_ff <= 1'h0;
      usb_pd_en_ff <= 1'h0;
    end else begin
      usb_hiz_ff <= !hold_s2_ff;
      usb_pd_en_ff <= !hold_s2_ff;
    end
  end

  assign scl_rise = scl_s2_ff && !scl_d_ff;
  assign scl_fall = !scl_s2_ff && scl_d_ff;
  // Bus conditions: SDA moves while SCL is high
  assign start_cond = scl_s2_ff && scl_d_ff && !sda_s2_ff && sda_d_ff;
  assign stop_cond = scl_s2_ff && scl_d_ff && sda_s2_ff && !sda_d_ff;
  assign byte_done = bit_cnt_ff == i2ct_pkg::I2CT_BITS_PER_BYTE;
  // Ninth clock of every byte is an acknowledge slot, not a data bit
  assign ack_slot = state_ff == i2ct_pkg::I2CT_ADDR_ACK ||
                    state_ff == i2ct_pkg::I2CT_OFFS_ACK ||
                    state_ff == i2ct_pkg::I2CT_WDATA_ACK ||
                    state_ff == i2ct_pkg::I2CT_RACK;
  // General call 0x00 never matches the fixed high bits
  assign addr_match = strap_done_ff &&
      shift_ff[7:1] == {i2ct_pkg::I2CT_ADDR_HI, addr_sel_ff,
                        i2ct_pkg::I2CT_ADDR_LO};

  // Bit counter and input shift register, sampled on SCL rise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (start_cond) begin
      bit_cnt_ff <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (state_ff != i2ct_pkg::I2CT_RDATA) begin
        shift_ff <= {shift_ff[6:0], sda_s2_ff};
      end
    end else if (scl_fall && (byte_done || ack_slot)) begin
      // Restart after the acknowledge clock so it never counts as a bit
      bit_cnt_ff <= 4'h0;
      if (state_ff == i2ct_pkg::I2CT_RACK ||
          state_ff == i2ct_pkg::I2CT_ADDR_ACK) begin
        shift_ff <= rd_data;
      end
    end else if (scl_fall && state_ff == i2ct_pkg::I2CT_RDATA) begin
      shift_ff <= {shift_ff[6:0], 1'h1};
    end
  end

  // Transaction sequencer; a restart may arrive in any state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= i2ct_pkg::I2CT_IDLE;
      rd_dir_ff <= 1'h0;
      master_ack_ff <= 1'h0;
    end else if (start_cond) begin
      state_ff <= i2ct_pkg::I2CT_ADDR;
    end else if (stop_cond) begin
      state_ff <= i2ct_pkg::I2CT_IDLE;
    end else begin
      unique case (state_ff)
        i2ct_pkg::I2CT_IDLE: begin
        end
        i2ct_pkg::I2CT_ADDR: begin
          if (scl_fall && byte_done) begin
            rd_dir_ff <= shift_ff[0];
            state_ff <= addr_match ? i2ct_pkg::I2CT_ADDR_ACK :
                                     i2ct_pkg::I2CT_IDLE;
          end
        end
        i2ct_pkg::I2CT_ADDR_ACK: begin
          if (scl_fall) begin
            state_ff <= rd_dir_ff ? i2ct_pkg::I2CT_RDATA :
                                    i2ct_pkg::I2CT_OFFS;
          end
        end
        i2ct_pkg::I2CT_OFFS: begin
          if (scl_fall && byte_done) begin
            state_ff <= i2ct_pkg::I2CT_OFFS_ACK;
          end
        end
        i2ct_pkg::I2CT_OFFS_ACK: begin
          if (scl_fall) begin
            state_ff <= i2ct_pkg::I2CT_WDATA;
          end
        end
        i2ct_pkg::I2CT_WDATA: begin
          if (scl_fall && byte_done) begin
            state_ff <= i2ct_pkg::I2CT_WDATA_ACK;
          end
        end
        i2ct_pkg::I2CT_WDATA_ACK: begin
          if (scl_fall) begin
            state_ff <= i2ct_pkg::I2CT_WDATA;
          end
        end
        i2ct_pkg::I2CT_RDATA: begin
          if (scl_fall && byte_done) begin
            state_ff <= i2ct_pkg::I2CT_RACK;
          end
        end
        i2ct_pkg::I2CT_RACK: begin
          if (scl_rise) begin
            master_ack_ff <= !sda_s2_ff;
          end else if (scl_fall) begin
            // NACK ends the read; wait for STOP or restart
            state_ff <= master_ack_ff ? i2ct_pkg::I2CT_RDATA :
                                        i2ct_pkg::I2CT_IDLE;
          end
        end
      endcase
    end
  end

  // Offset pointer; 8-bit increment wraps FF to 00
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr_ff <= 8'h00;
    end else if (scl_fall && byte_done &&
                 state_ff == i2ct_pkg::I2CT_OFFS) begin
      ptr_ff <= shift_ff;
    end else if (scl_fall && byte_done &&
                 (state_ff == i2ct_pkg::I2CT_WDATA ||
                  state_ff == i2ct_pkg::I2CT_RDATA)) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // Write strobe only once the whole byte is in
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_en_ff <= 1'h0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_en_ff <= scl_fall && byte_done &&
                  state_ff == i2ct_pkg::I2CT_WDATA;
      wr_data_ff <= shift_ff;
    end
  end

  // Open-drain SDA: enable low pulls the line low, changes on SCL fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_o_ff <= 1'h0;
      sda_oe_n_ff <= 1'h1;
    end else if (start_cond || stop_cond) begin
      sda_oe_n_ff <= 1'h1;
    end else if (scl_fall) begin
      unique case (state_ff)
        i2ct_pkg::I2CT_ADDR: sda_oe_n_ff <= !(byte_done && addr_match);
        i2ct_pkg::I2CT_OFFS: sda_oe_n_ff <= !byte_done;
        i2ct_pkg::I2CT_WDATA: sda_oe_n_ff <= !byte_done;
        i2ct_pkg::I2CT_ADDR_ACK: sda_oe_n_ff <= !rd_dir_ff || rd_data[7];
        i2ct_pkg::I2CT_RDATA: begin
          sda_oe_n_ff <= byte_done ? 1'h1 : shift_ff[6];
        end
        i2ct_pkg::I2CT_RACK: sda_oe_n_ff <= !master_ack_ff || rd_data[7];
        default: sda_oe_n_ff <= 1'h1;
      endcase
    end
  end

  // Write address lags the pointer by one cycle, so the write uses the old offset
  logic [7:0] wr_addr_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_addr_ff <= 8'h00;
    end else begin
      wr_addr_ff <= ptr_ff;
    end
  end

  i2ct_regfile u_regs (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .hold_clr(!hold_s2_ff),
    .wr_en(wr_en_ff),
    .wr_addr(wr_addr_ff),
    .wr_data(wr_data_ff),
    .rd_addr(ptr_ff),
    .rd_data_ff(rd_data),
    .dev_status(dev_status),
    .link_status(link_status),
    .cfg_regs(cfg_regs)
  );
endmodule
`default_nettype wire

// ### tb/i2ct_checker.sv
// Port-level assertions for the I2C target front end
`timescale 1ns/1ps
`default_nettype none
module i2ct_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_oe_n_ff,
  input wire logic [1:0] strap_level,
  input wire logic hold_rst_n,
  input wire logic [8*i2ct_pkg::I2CT_CFG_BYTES-1:0] cfg_regs,
  input wire logic [1:0] addr_sel_ff,
  input wire logic usb_hiz_ff,
  input wire logic usb_pd_en_ff
);
  logic [3:0] rel_cnt_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Cycles since reset release, saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rel_cnt_ff <= 4'h0;
    end else if (rel_cnt_ff != 4'hF) begin
      rel_cnt_ff <= rel_cnt_ff + 4'h1;
    end
  end

  sequence s_hold_low;
    !hold_rst_n [*5];
  endsequence
  // Clock high this long means no byte can be ending
  sequence s_bus_quiet;
    (scl_i && hold_rst_n) [*6];
  endsequence

  a_rst_defaults: assert property ($past(sys_rst) |->
    cfg_regs[71:0] == 72'h02_6322_4010_2000_0000)
    else $error("defaults missing after reset");
  a_strap_map: assert property (rel_cnt_ff == 4'hD |->
    addr_sel_ff == strap_level) else $error("address bits not strap");
  a_strap_held: assert property (rel_cnt_ff == 4'hF |->
    $stable(addr_sel_ff)) else $error("address bits moved");
  a_hold_hiz: assert property (s_hold_low |->
    usb_hiz_ff && usb_pd_en_ff) else $error("pins not released in hold");
  a_hold_free: assert property (hold_rst_n [*5] |-> !usb_hiz_ff)
    else $error("pins high-Z without hold");
  a_hiz_pd_pair: assert property (usb_hiz_ff == usb_pd_en_ff)
    else $error("pull-downs and high-Z disagree");
  a_bit_stable: assert property (scl_i [*6] |-> $stable(sda_oe_n_ff))
    else $error("data moved while clock high");
  a_cfg_commit: assert property (s_bus_quiet |-> $stable(cfg_regs))
    else $error("register changed mid byte");
endmodule

bind i2ct_target i2ct_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .scl_i(scl_i), .sda_oe_n_ff(sda_oe_n_ff), .strap_level(strap_level),
  .hold_rst_n(hold_rst_n), .cfg_regs(cfg_regs), .addr_sel_ff(addr_sel_ff),
  .usb_hiz_ff(usb_hiz_ff), .usb_pd_en_ff(usb_pd_en_ff));
`default_nettype wire

// ### tb/i2ct_ctrl_model.sv
// Behavioural I2C bus controller for the target's link
`timescale 1ns/1ps
`default_nettype none
module i2ct_ctrl_model (
  input wire logic sys_clk,
  input wire logic sda_in,
  output logic scl_ff,
  output logic sda_ff
);
  // Open-drain: 1 lets the pull-up take the line
  initial begin
    scl_ff = 1'b1;
    sda_ff = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Restart waits for the target to let go of data first
  task automatic start;
    tick(3);
    sda_ff <= 1'b1;
    tick(2);
    scl_ff <= 1'b1;
    tick(3);
    sda_ff <= 1'b0;
    tick(3);
    scl_ff <= 1'b0;
  endtask
  task automatic stop;
    tick(3);
    sda_ff <= 1'b0;
    tick(2);
    scl_ff <= 1'b1;
    tick(3);
    sda_ff <= 1'b1;
    tick(3);
  endtask
  // Low 5, high 3: data settles before the target sees the rise
  task automatic bit_x(input logic b, output logic r);
    tick(3);
    sda_ff <= b;
    tick(2);
    scl_ff <= 1'b1;
    tick(2);
    r = sda_in;
    tick(1);
    scl_ff <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] wb, input logic ninth,
    output logic [7:0] rb, output logic nine);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(wb[i], b);
      rb = {rb[6:0], b};
    end
    bit_x(ninth, nine);
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the I2C target front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hold_n = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [7:0] dev_st = 8'hC3;
  logic [7:0] link_st = 8'h5E;
  logic [8*i2ct_pkg::I2CT_CFG_BYTES-1:0] cfg;
  logic [1:0] sel;
  logic hiz, pd, sda_o, sda_oe_n, scl, sda_c;
  logic [6:0] dev;
  int n_fail = 0;
  int comparisons = 0;
  wire logic sda = sda_c & (sda_oe_n | sda_o);
  always #10 sys_clk = ~sys_clk;
  i2ct_ctrl_model i_ctl (.sys_clk(sys_clk), .sda_in(sda), .scl_ff(scl),
    .sda_ff(sda_c));
  i2ct_target i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl),
    .sda_i(sda), .sda_o_ff(sda_o), .sda_oe_n_ff(sda_oe_n),
    .strap_level(strap), .hold_rst_n(hold_n), .dev_status(dev_st),
    .link_status(link_st), .cfg_regs(cfg), .addr_sel_ff(sel),
    .usb_hiz_ff(hiz), .usb_pd_en_ff(pd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    logic [7:0] r;
    logic nine;
    i_ctl.xfer(b, 1'b1, r, nine);
    chk({7'h0, ~nine}, {7'h0, ack});
  endtask
  task automatic rd(input logic [7:0] exp, input logic last);
    logic [7:0] r;
    logic nine;
    i_ctl.xfer(8'hFF, last, r, nine);
    chk(r, exp);
  endtask
  task automatic open_at(input logic [7:0] ofs, input logic rdx);
    i_ctl.start;
    send({dev, 1'b0}, 1'b1);
    send(ofs, 1'b1);
    if (rdx) begin
      i_ctl.start;
      send({dev, 1'b1}, 1'b1);
    end
  endtask
  task automatic do_rst(input logic [1:0] s);
    strap <= s;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (25) @(posedge sys_clk);
    dev = {i2ct_pkg::I2CT_ADDR_HI, s, i2ct_pkg::I2CT_ADDR_LO};
  endtask
  task automatic t_addr;
    for (int s = 0; s < 4; s++) begin
      do_rst(2'(s));
      chk({6'h0, sel}, 8'(s));
      strap <= ~2'(s);
      i_ctl.start;
      send({dev, 1'b0}, 1'b1);
      i_ctl.start;
      send({dev ^ 7'h04, 1'b0}, 1'b0);
      i_ctl.stop;
      chk({6'h0, sel}, 8'(s));
    end
    i_ctl.start;
    send(8'h00, 1'b0);
    i_ctl.stop;
  endtask
  task automatic t_write;
    logic [7:0] d [14] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h10, 8'h40,
      8'h22, 8'h63, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic r;
    for (int k = 0; k < 14; k++) chk(cfg[8*k +: 8], d[k]);
    open_at(8'h08, 1'b0);
    send(8'h5A, 1'b1);
    send(8'hA5, 1'b1);
    send(8'h3C, 1'b1);
    send(8'h99, 1'b1);
    i_ctl.stop;
    chk(cfg[87:56], 32'h003C_A55A);
    // Byte cut short by STOP must leave offset 0x0A alone
    open_at(8'h0A, 1'b0);
    repeat (4) i_ctl.bit_x(1'b0, r);
    i_ctl.stop;
    chk(cfg[79:72], 8'h3C);
  endtask
  task automatic t_read;
    logic [7:0] e [10] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF, 8'hFF, 8'h00,
      8'h00, 8'hC3, 8'h5E, 8'h00};
    open_at(8'h08, 1'b1);
    for (int k = 0; k < 10; k++) rd(e[k], k == 9);
    i_ctl.stop;
  endtask
  task automatic t_wrap;
    open_at(8'hFF, 1'b0);
    send(8'h77, 1'b1);
    send(8'h12, 1'b1);
    send(8'h44, 1'b1);
    i_ctl.stop;
    chk(cfg[7:0], 8'h44);
    open_at(8'hFF, 1'b1);
    rd(8'hFF, 1'b0);
    rd(8'h00, 1'b0);
    rd(8'h44, 1'b1);
    i_ctl.stop;
  endtask
  task automatic t_hold;
    hold_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({6'h0, hiz, pd}, 8'h03);
    hold_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({6'h0, hiz, pd}, 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    t_addr;
    t_write;
    t_read;
    t_wrap;
    t_hold;
    end_of_test;
  end
  // Whole run needs well under 10000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule
`default_nettype wire
